// >>> design/tone_modulator.sv
// Tone command modulator with transmit queue and register port
`timescale 1ns/1ps

// Behaviour
// - Queued bytes are sent by gating a tone near 22 kHz.
// - Tone clock is divided down from the system clock.
// - Empty and full flags are readable on the register port.
// - After reset the queue is empty, empty set, full clear.
// - Sending starts as soon as one byte is queued.
// - After the last byte and parity the block returns idle.
// - Idle keeps modulation inactive.
// - Bytes go MSB first then an odd parity bit.
// - Each bit lasts 33 tone periods.
// - Shape select 1: zero is 22 periods on, 11 off.
// - Shape select 0: zero is on for all 33 periods.
// - A one is 11 periods on, 22 off.
// - Active modulation toggles the pin at the tone rate.
// - Inactive output follows mode: 00 low, 01 high, 10 high impedance.
// - Mode 11 outputs the tone continuously.
module tone_modulator (
	input  wire logic       clk_in,     // System clock, 10 MHz
	input  wire logic       rst_n_in,   // Async reset, active low
	input  wire logic [3:0] addr_in,    // Register address
	input  wire logic [7:0] wdata_in,   // Write data
	input  wire logic       wr_in,      // Write strobe
	input  wire logic       rd_in,      // Read strobe
	output logic      [7:0] rdata_out,  // Read data, cycle after strobe
	output logic            line_o_out, // Tone line output level
	output logic            line_oe_n_out // Tone line enable, low drives
);
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_SEND
	} tx_state_e;

	//////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [2:0]  control_q;
	logic [15:0] half_div_q;
	logic [7:0]  fifo_mem [tone_pkg::FIFO_DEPTH];
	logic [tone_pkg::PTR_W-1:0] wr_ptr_q;
	logic [tone_pkg::PTR_W-1:0] rd_ptr_q;
	logic [tone_pkg::PTR_W:0]   count_q;
	tx_state_e   state_q;
	logic [8:0]  shift_q;
	logic [3:0]  bit_idx_q;
	logic [5:0]  period_q;
	logic        tone;
	logic        period_end;
	logic        push;
	logic        pop;
	logic        fifo_empty_flag;
	logic        fifo_full_flag;
	logic        bit_end;
	logic        active;
	logic        shape;
	logic [1:0]  output_mode_select;

	assign output_mode_select = control_q[tone_pkg::CTL_MODE_LSB +: 2];
	assign shape = control_q[tone_pkg::CTL_SHAPE_BIT];

	function automatic logic parity_odd(input logic [7:0] b);
		parity_odd = ~(^b);
	endfunction

	// Write strobe aimed at one register offset
	function automatic logic write_hit(input logic       wr,
	                                   input logic [3:0] addr,
	                                   input logic [3:0] target);
		write_hit = wr && (addr == target);
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// Tone source
	tone_divider u_div (
		.clk_in     (clk_in),
		.rst_n_in   (rst_n_in),
		.half_div_in(half_div_q),
		.tone_out   (tone),
		.period_out (period_end)
	);

	//////////////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			control_q <= tone_pkg::CONTROL_RESET;
		end else if (write_hit(wr_in, addr_in, tone_pkg::ADDR_CONTROL)) begin
			control_q <= wdata_in[2:0];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			half_div_q <= tone_pkg::HALF_DIV_RESET;
		end else if (write_hit(wr_in, addr_in, tone_pkg::ADDR_DIVIDER) && wdata_in != 8'h00) begin
			half_div_q <= {8'h00, wdata_in};
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Transmit queue
	// empty after reset
	assign fifo_empty_flag = (count_q == '0);
	assign fifo_full_flag = (count_q == (tone_pkg::PTR_W+1)'(tone_pkg::FIFO_DEPTH));
	assign push = write_hit(wr_in, addr_in, tone_pkg::ADDR_DATA) && !fifo_full_flag;
	assign bit_end = period_end && (period_q == tone_pkg::BIT_PERIODS - 6'h01);
	// load next byte when idle or at end of parity
	assign pop = !fifo_empty_flag &&
		(state_q == ST_IDLE || (bit_end && bit_idx_q == tone_pkg::LAST_BIT_IDX));

	always_ff @(posedge clk_in) begin
		if (push) begin
			fifo_mem[wr_ptr_q] <= wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Serialiser
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q   <= ST_IDLE;
			shift_q   <= 9'h000;
			bit_idx_q <= 4'h0;
			period_q  <= 6'h00;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (pop) begin
						shift_q   <= {fifo_mem[rd_ptr_q], parity_odd(fifo_mem[rd_ptr_q])};
						bit_idx_q <= 4'h0;
						period_q  <= 6'h00;
						state_q   <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (period_end) begin
						if (bit_end) begin
							period_q <= 6'h00;
							if (bit_idx_q == tone_pkg::LAST_BIT_IDX) begin
								bit_idx_q <= 4'h0;
								if (pop) begin
									shift_q <= {fifo_mem[rd_ptr_q],
										parity_odd(fifo_mem[rd_ptr_q])};
								end else begin
									state_q <= ST_IDLE;
								end
							end else begin
								bit_idx_q <= bit_idx_q + 4'h1;
								shift_q   <= {shift_q[7:0], 1'b0};
							end
						end else begin
							period_q <= period_q + 6'h01;
						end
					end
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Pulse shaping
	always_comb begin
		active = 1'b0;
		if (state_q == ST_SEND) begin
			if (shift_q[8]) begin
				active = period_q < tone_pkg::ONE_ACTIVE;
			end else if (shape) begin
				active = period_q < tone_pkg::ZERO_ACTIVE_S;
			end else begin
				active = 1'b1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Output pin
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			line_o_out    <= 1'b0;
			line_oe_n_out <= 1'b0;
		end else if (active || output_mode_select == tone_pkg::MODE_CONTINUOUS) begin
			line_o_out    <= tone;
			line_oe_n_out <= 1'b0;
		end else begin
			line_o_out    <= (output_mode_select == tone_pkg::MODE_HIGH);
			line_oe_n_out <= (output_mode_select == tone_pkg::MODE_HIGHZ);
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Read port
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			unique case (addr_in)
				tone_pkg::ADDR_CONTROL: rdata_out <= {5'h00, control_q};
				tone_pkg::ADDR_STATUS: begin
					rdata_out <= 8'h00;
					rdata_out[tone_pkg::STS_EMPTY_BIT] <= fifo_empty_flag;
					rdata_out[tone_pkg::STS_FULL_BIT]  <= fifo_full_flag;
					rdata_out[tone_pkg::STS_BUSY_BIT]  <= (state_q == ST_SEND);
				end
				tone_pkg::ADDR_DIVIDER: rdata_out <= half_div_q[7:0];
				default: rdata_out <= 8'h00;
			endcase
		end else begin
			rdata_out <= 8'h00;
		end
	end
endmodule

// >>> pkg/tone_pkg.sv
// Constants for the tone command modulator
package tone_pkg;
	// Register offsets
	localparam logic [3:0] ADDR_DATA    = 4'h0;
	localparam logic [3:0] ADDR_CONTROL = 4'h1;
	localparam logic [3:0] ADDR_STATUS  = 4'h2;
	localparam logic [3:0] ADDR_DIVIDER = 4'h3;
	// Control fields
	localparam int CTL_MODE_LSB  = 0;
	localparam int CTL_SHAPE_BIT = 2;
	localparam logic [2:0] CONTROL_RESET = 3'h0;
	// Status fields
	localparam int STS_EMPTY_BIT = 0;
	localparam int STS_FULL_BIT  = 1;
	localparam int STS_BUSY_BIT  = 2;
	// Output modes
	localparam logic [1:0] MODE_LOW        = 2'h0;
	localparam logic [1:0] MODE_HIGH       = 2'h1;
	localparam logic [1:0] MODE_HIGHZ      = 2'h2;
	localparam logic [1:0] MODE_CONTINUOUS = 2'h3;
	// Tone and symbol timing
	localparam int CLK_HZ        = 10_000_000;
	localparam int TONE_HZ       = 22_000;
	localparam int HALF_DIV_INT  = CLK_HZ / (2 * TONE_HZ);
	localparam logic [15:0] HALF_DIV_RESET = 16'(HALF_DIV_INT);
	localparam logic [5:0] BIT_PERIODS   = 6'h21;
	localparam logic [5:0] ONE_ACTIVE    = 6'h0B;
	localparam logic [5:0] ZERO_ACTIVE_S = 6'h16;
	localparam logic [3:0] LAST_BIT_IDX  = 4'h8;
	// Queue depth
	localparam int FIFO_DEPTH = 8;
	localparam int PTR_W      = 3;
endpackage

// >>> design/tone_divider.sv
// Tone clock divider
`timescale 1ns/1ps
module tone_divider (
	input  wire logic        clk_in,       // System clock
	input  wire logic        rst_n_in,     // Async reset, active low
	input  wire logic [15:0] half_div_in,  // Clocks per half tone period
	output logic             tone_out,     // Tone square wave
	output logic             period_out    // Pulse at end of tone period
);
	logic [15:0] cnt_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_q <= 16'h0000;
		end else if (cnt_q + 16'h0001 >= half_div_in) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tone_out <= 1'b0;
		end else if (cnt_q + 16'h0001 >= half_div_in) begin
			tone_out <= ~tone_out;
		end
	end

	assign period_out = (cnt_q + 16'h0001 >= half_div_in) && tone_out;
endmodule

// >>> test/tone_modulator_checker.sv
// Port assertions for the tone modulator
`timescale 1ns/1ps
module tone_modulator_checker (
	input wire logic       clk_in,
	input wire logic       rst_n_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic       wr_in,
	input wire logic       rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic       line_o_out,
	input wire logic       line_oe_n_out
);
	logic [1:0]  mode_q;
	logic [7:0]  div_q;
	logic [15:0] run_q;
	logic [15:0] settle_q;
	logic [15:0] div_w;
	logic        last_q;
	logic        steady;
	// Tone runs are judged only once the divider has settled
	assign steady = settle_q > 16'h0258;
	assign div_w  = {8'h00, div_q};
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_q   <= 2'h0;
			div_q    <= tone_pkg::HALF_DIV_RESET[7:0];
			settle_q <= 16'h0;
			last_q   <= 1'b0;
			run_q    <= 16'h0;
		end else begin
			last_q <= line_o_out;
			run_q  <= (line_o_out != last_q) ? 16'h1 : run_q + 16'h1;
			settle_q <= steady ? settle_q : settle_q + 16'h1;
			if (wr_in && addr_in == tone_pkg::ADDR_CONTROL) begin
				mode_q   <= wdata_in[1:0];
				settle_q <= 16'h0;
			end
			if (wr_in && addr_in == tone_pkg::ADDR_DIVIDER && wdata_in != 8'h00) begin
				div_q    <= wdata_in;
				settle_q <= 16'h0;
			end
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	sequence s_rd_status;
		rd_in && addr_in == tone_pkg::ADDR_STATUS;
	endsequence
	sequence s_rd_unmapped;
		rd_in && addr_in > tone_pkg::ADDR_DIVIDER;
	endsequence
	sequence s_tone_edge;
		steady && mode_q == tone_pkg::MODE_CONTINUOUS ##0 line_o_out != last_q;
	endsequence
	AST_RESET_IDLE: assert property (disable iff (1'b0) !rst_n_in |->
		rdata_out == 8'h00 && !line_o_out && !line_oe_n_out) else $error("reset state");
	AST_READ_QUIET: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
		else $error("read data outside slot");
	AST_UNMAPPED: assert property (s_rd_unmapped |=> rdata_out == 8'h00)
		else $error("unmapped read");
	AST_STATUS: assert property (s_rd_status |=> rdata_out[7:3] == 5'h00
		&& !(rdata_out[0] && rdata_out[1])) else $error("status bits");
	AST_HIGHZ_MODE: assert property (line_oe_n_out |-> $past(mode_q) == tone_pkg::MODE_HIGHZ)
		else $error("released outside mode 2");
	AST_DRIVE_MODE: assert property ($past(mode_q) != tone_pkg::MODE_HIGHZ |-> !line_oe_n_out)
		else $error("line not driven");
	AST_TONE_HALF: assert property (s_tone_edge |-> run_q == div_w)
		else $error("tone half period");
	AST_LOW_IDLE: assert property (steady && mode_q == tone_pkg::MODE_LOW
		&& line_o_out && line_o_out == last_q |-> run_q < div_w) else $error("high too long");
	AST_HIGH_IDLE: assert property (steady && mode_q == tone_pkg::MODE_HIGH
		&& !line_o_out && line_o_out == last_q |-> run_q < div_w) else $error("low too long");
endmodule

bind tone_modulator tone_modulator_checker i_tone_modulator_checker (.clk_in, .rst_n_in,
	.addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .line_o_out, .line_oe_n_out);

// >>> test/lnb_line_model.sv
// Receiver on the tone line: counts tone edges, decodes burst widths
`timescale 1ns/1ps
module lnb_line_model #(
	parameter int GAP_CLKS = 12 // Silence that closes a burst
) (
	input  wire logic        clk_in,       // System clock
	input  wire logic        rst_n_in,     // Async reset, active low
	input  wire logic        line_o_in,    // Driven level
	input  wire logic        line_oe_n_in, // Low while driven
	output logic      [15:0] edges_out,    // Rising edges seen
	output logic      [8:0]  bits_out,     // Last bits, first in MSB
	output logic      [7:0]  nbits_out     // Bits decoded
);
	logic       lvl;
	logic       last_q;
	logic [7:0] burst_q;
	logic [7:0] gap_q;
	// Released line rests high through its bias
	assign lvl = line_oe_n_in ? 1'b1 : line_o_in;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			last_q    <= 1'b0;
			edges_out <= 16'h0;
			bits_out  <= 9'h0;
			nbits_out <= 8'h0;
			burst_q   <= 8'h0;
			gap_q     <= 8'h0;
		end else begin
			last_q <= lvl;
			if (lvl && !last_q) begin
				edges_out <= edges_out + 16'h1;
				burst_q   <= burst_q + 8'h1;
				gap_q     <= 8'h0;
			end else if (gap_q < 8'(GAP_CLKS)) begin
				gap_q <= gap_q + 8'h1;
			end else if (burst_q != 8'h0) begin
				// Short bursts read as ones
				bits_out  <= {bits_out[7:0], burst_q < 8'h11};
				nbits_out <= nbits_out + 8'h1;
				burst_q   <= 8'h0;
			end
		end
	end
endmodule

// >>> test/tone_modulator_test.sv
// Self-checking bench for the tone modulator
`timescale 1ns/1ps
module tone_modulator_test;
	logic        clk_in;
	logic        rst_n_in = 1'b0;
	logic        wr_in    = 1'b0;
	logic        rd_in    = 1'b0;
	logic [3:0]  addr_in  = 4'h0;
	logic [7:0]  wdata_in = 8'h00;
	logic [7:0]  rdata_out;
	logic        line_o_out;
	logic        line_oe_n_out;
	logic [15:0] edges;
	logic [15:0] e0;
	logic [8:0]  bits;
	logic [7:0]  nbits;
	logic [7:0]  n0;
	int          fails    = 0;
	int          checks   = 0;
	tone_modulator i_tone_modulator (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in,
		.rd_in, .rdata_out, .line_o_out, .line_oe_n_out);
	lnb_line_model i_lnb_line_model (.clk_in, .rst_n_in, .line_o_in(line_o_out),
		.line_oe_n_in(line_oe_n_out), .edges_out(edges), .bits_out(bits), .nbits_out(nbits));
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic near(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
		checks++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, hi);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 v = rdata_out;
	endtask
	task automatic chk(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		cmp({8'h00, v}, {8'h00, exp});
	endtask
	task automatic push(input logic [7:0] d);
		logic [7:0] s;
		for (int n = 0; n < 3000; n++) begin
			rd(tone_pkg::ADDR_STATUS, s);
			if (s[tone_pkg::STS_FULL_BIT] === 1'b0) break;
		end
		wr(tone_pkg::ADDR_DATA, d);
	endtask
	task automatic conclude;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_idle;
		e0 = edges;
		repeat (200) @(posedge clk_in);
		chk(tone_pkg::ADDR_STATUS, 8'h01);
		chk(4'hF, 8'h00);
		cmp(edges - e0, 16'h0);
		$display("idle done");
	endtask
	task automatic t_modes;
		logic [1:0] m;
		wr(tone_pkg::ADDR_DIVIDER, 8'h02);
		for (int i = 0; i < 3; i++) begin
			m = 2'(i);
			wr(tone_pkg::ADDR_CONTROL, {6'h00, m});
			repeat (4) @(posedge clk_in);
			cmp({14'h0, line_oe_n_out, line_o_out & ~line_oe_n_out}, {14'h0, m == 2'h2, m == 2'h1});
		end
		wr(tone_pkg::ADDR_CONTROL, {6'h00, tone_pkg::MODE_CONTINUOUS});
		repeat (800) @(posedge clk_in);
		e0 = edges;
		repeat (40) @(posedge clk_in);
		near(edges - e0, 16'h9, 16'hB);
		$display("modes done");
	endtask
	task automatic t_burst;
		wr(tone_pkg::ADDR_CONTROL, 8'h04);
		repeat (4) @(posedge clk_in);
		e0 = edges;
		push(8'hFF);
		repeat (1300) @(posedge clk_in);
		near(edges - e0, 16'h62, 16'h63);
		chk(tone_pkg::ADDR_STATUS, 8'h01);
		cmp({14'h0, line_oe_n_out, line_o_out}, 16'h0);
		$display("burst done");
	endtask
	task automatic t_plain;
		wr(tone_pkg::ADDR_CONTROL, 8'h00);
		e0 = edges;
		push(8'h00);
		push(8'h00);
		repeat (2500) @(posedge clk_in);
		near(edges - e0, 16'h0225, 16'h0226);
		$display("plain done");
	endtask
	task automatic t_order;
		wr(tone_pkg::ADDR_CONTROL, 8'h06);
		repeat (20) @(posedge clk_in);
		n0 = nbits;
		push(8'hA5);
		repeat (1300) @(posedge clk_in);
		cmp(16'(nbits - n0), 16'h9);
		cmp(16'(bits), 16'h014B);
		cmp({15'h0, line_oe_n_out}, 16'h1);
		$display("order done");
	endtask
	task automatic t_full;
		wr(tone_pkg::ADDR_CONTROL, 8'h05);
		repeat (20) @(posedge clk_in);
		n0 = nbits;
		wr(tone_pkg::ADDR_DATA, 8'hFF);
		repeat (10) @(posedge clk_in);
		repeat (9) wr(tone_pkg::ADDR_DATA, 8'hFF);
		chk(tone_pkg::ADDR_STATUS, 8'h06);
		repeat (10800) @(posedge clk_in);
		cmp(16'(nbits - n0), 16'h0051);
		chk(tone_pkg::ADDR_STATUS, 8'h01);
		$display("full done");
	endtask
	initial begin
		repeat (40000) @(posedge clk_in);
		fails++;
		conclude;
	end
	initial begin
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_idle;
		t_modes;
		t_burst;
		t_plain;
		t_order;
		t_full;
		conclude;
	end
endmodule
